// ---- hdl/dzcd_front.sv ----
// Channel delay, zero-pad and six-stage decimator with APB registers
`timescale 1ns/1ns
`default_nettype none
module dzcd_front #(
  parameter int unsigned NUM_SYNC = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SYNC-1:0] sync_in,
  input wire dzcd_pkg::dzcd_iq_s in_a,
  input wire dzcd_pkg::dzcd_iq_s in_b,
  output logic out_valid,
  output dzcd_pkg::dzcd_out_s out_a,
  output dzcd_pkg::dzcd_out_s out_b
);
  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (NUM_SYNC != 8) begin : g_bad_sync
    $error("Sync selector needs exactly eight sources");
  end

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [31:0] ctrl_q, delay_q, sync_q, cic_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic [2:0] coarse_a_q, coarse_b_q, fine_a_q, fine_b_q;
  logic [4:0] dec_cnt_q;
  logic wr_en;
  logic [31:0] rd_mux;
  logic rd_err;

  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = psel & penable & err_q;

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr == dzcd_pkg::OFS_CTRL) begin
      rd_mux = ctrl_q;
    end else if (paddr == dzcd_pkg::OFS_DELAY) begin
      rd_mux = delay_q;
    end else if (paddr == dzcd_pkg::OFS_SYNC) begin
      rd_mux = sync_q;
    end else if (paddr == dzcd_pkg::OFS_CIC) begin
      rd_mux = cic_q;
    end else if (paddr == dzcd_pkg::OFS_STAT) begin
      rd_mux = {11'h000, dec_cnt_q, 1'b0, fine_b_q, 1'b0, fine_a_q,
                1'b0, coarse_b_q, 1'b0, coarse_a_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  // Setup phase captures the answer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q <= rd_err | (pwrite && paddr == dzcd_pkg::OFS_STAT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= dzcd_pkg::CTRL_RST;
      delay_q <= dzcd_pkg::ZERO_RST;
      sync_q <= dzcd_pkg::ZERO_RST;
      cic_q <= dzcd_pkg::ZERO_RST;
    end else if (wr_en) begin
      if (paddr == dzcd_pkg::OFS_CTRL) begin
        ctrl_q <= pwdata & 32'h001f_01ff;
      end else if (paddr == dzcd_pkg::OFS_DELAY) begin
        delay_q <= pwdata & 32'h0000_7777;
      end else if (paddr == dzcd_pkg::OFS_SYNC) begin
        sync_q <= pwdata & 32'h0000_0777;
      end else if (paddr == dzcd_pkg::OFS_CIC) begin
        cic_q <= pwdata & 32'h3f3f_1f1f;
      end
    end
  end

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  logic two_chan, cic_gain, cic_bypass;
  logic [1:0] rate_sel;
  logic [2:0] interp_code;
  logic [4:0] dec_field;
  logic [4:0] scale_a, scale_b;
  logic [5:0] mask_a, mask_b;
  logic sync_fine, sync_reg, sync_cic;

  assign two_chan = ctrl_q[dzcd_pkg::CT_TWO];
  assign rate_sel = ctrl_q[dzcd_pkg::CT_RATE +: 2];
  assign interp_code = ctrl_q[dzcd_pkg::CT_INTERP +: 3];
  assign cic_gain = ctrl_q[dzcd_pkg::CT_GAIN];
  assign cic_bypass = ctrl_q[dzcd_pkg::CT_BYP];
  assign dec_field = ctrl_q[dzcd_pkg::CT_DEC +: 5];
  assign scale_a = cic_q[dzcd_pkg::CI_SA +: 5];
  assign scale_b = cic_q[dzcd_pkg::CI_SB +: 5];
  assign mask_a = cic_q[dzcd_pkg::CI_MA +: 6];
  assign mask_b = cic_q[dzcd_pkg::CI_MB +: 6];
  assign sync_fine = sync_in[sync_q[dzcd_pkg::SY_FINE +: 3]];
  assign sync_reg = sync_in[sync_q[dzcd_pkg::SY_REG +: 3]];
  assign sync_cic = sync_in[sync_q[dzcd_pkg::SY_CIC +: 3]];

  // ------------------------------------------------------------
  // Working copies of delay settings
  // ------------------------------------------------------------
  // load on register sync pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      coarse_a_q <= 3'h0;
      coarse_b_q <= 3'h0;
      fine_a_q <= 3'h0;
      fine_b_q <= 3'h0;
    end else if (sync_reg) begin
      coarse_a_q <= delay_q[dzcd_pkg::DL_CA +: 3];
      coarse_b_q <= delay_q[dzcd_pkg::DL_CB +: 3];
      fine_a_q <= delay_q[dzcd_pkg::DL_FA +: 3];
      fine_b_q <= delay_q[dzcd_pkg::DL_FB +: 3];
    end
  end

  // ------------------------------------------------------------
  // Input pacing and delay memory
  // ------------------------------------------------------------
  logic [2:0] rate_cnt_q;
  logic [2:0] rate_max;
  logic rate_tick;
  logic [dzcd_pkg::PTR_W-1:0] wptr_q;
  dzcd_pkg::dzcd_iq_s mem_a_q [dzcd_pkg::DLY_DEPTH];
  dzcd_pkg::dzcd_iq_s mem_b_q [dzcd_pkg::DLY_DEPTH];

  always_comb begin
    case (rate_sel)
      2'h0: rate_max = 3'h0;
      2'h1: rate_max = 3'h1;
      2'h2: rate_max = 3'h3;
      default: rate_max = 3'h7;
    endcase
  end
  assign rate_tick = (rate_cnt_q == 3'h0);

  always_ff @(posedge ref_clk) begin
    if (reset || sync_fine) begin
      rate_cnt_q <= 3'h0;
    end else if (rate_cnt_q >= rate_max) begin
      rate_cnt_q <= 3'h0;
    end else begin
      rate_cnt_q <= rate_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wptr_q <= '0;
    end else if (rate_tick) begin
      wptr_q <= wptr_q + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rate_tick) begin
      mem_a_q[wptr_q] <= in_a;
      mem_b_q[wptr_q] <= in_b;
    end
  end

  logic [2:0] rptr_a, rptr_b;
  assign rptr_a = wptr_q - 3'h1 - coarse_a_q;
  assign rptr_b = wptr_q - 3'h1 - coarse_b_q;

  // ------------------------------------------------------------
  // Zero stuffing
  // ------------------------------------------------------------
  logic [2:0] interp_max;
  logic [2:0] stuff_a_q, stuff_b_q;
  dzcd_pkg::dzcd_iq_s pad_a_q, pad_b_q;

  always_comb begin
    case (interp_code)
      3'h1: interp_max = 3'h1;
      3'h2: interp_max = 3'h3;
      3'h3: interp_max = 3'h7;
      default: interp_max = 3'h0;
    endcase
  end

  // phase restarts at sync plus fine offset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stuff_a_q <= 3'h0;
      stuff_b_q <= 3'h0;
    end else if (sync_fine) begin
      stuff_a_q <= fine_a_q & interp_max;
      stuff_b_q <= (two_chan ? fine_b_q : fine_a_q) & interp_max;
    end else begin
      stuff_a_q <= (stuff_a_q == 3'h0) ? interp_max : stuff_a_q - 3'h1;
      stuff_b_q <= (stuff_b_q == 3'h0) ? interp_max : stuff_b_q - 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pad_a_q <= '0;
      pad_b_q <= '0;
    end else begin
      pad_a_q <= (stuff_a_q == 3'h0) ? mem_a_q[rptr_a] : '0;
      pad_b_q <= (two_chan && stuff_b_q == 3'h0) ? mem_b_q[rptr_b] : '0;
    end
  end

  // ------------------------------------------------------------
  // Decimation timing
  // ------------------------------------------------------------
  logic dec_tick;
  assign dec_tick = (dec_cnt_q == dec_field);

  always_ff @(posedge ref_clk) begin
    if (reset || sync_cic) begin
      dec_cnt_q <= 5'h00;
    end else if (dec_tick) begin
      dec_cnt_q <= 5'h00;
    end else begin
      dec_cnt_q <= dec_cnt_q + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // Decimator lanes: A.I, A.Q, B.I, B.Q
  // ------------------------------------------------------------
  logic [dzcd_pkg::SMP_W-1:0] lane_in [4];
  logic [dzcd_pkg::COMB_W-1:0] lane_out [4];
  assign lane_in[0] = pad_a_q.i;
  assign lane_in[1] = pad_a_q.q;
  assign lane_in[2] = pad_b_q.i;
  assign lane_in[3] = pad_b_q.q;

  for (genvar l = 0; l < 4; l++) begin : g_lane
    logic [dzcd_pkg::ACC_W-1:0] integ_q [dzcd_pkg::NSTAGE];
    logic [dzcd_pkg::COMB_W-1:0] d1_q [dzcd_pkg::NSTAGE];
    logic [dzcd_pkg::COMB_W-1:0] d2_q [dzcd_pkg::NSTAGE];
    logic [dzcd_pkg::COMB_W-1:0] cx [dzcd_pkg::NSTAGE+1];
    logic [dzcd_pkg::COMB_W-1:0] res_q;
    logic [5:0] mask;
    logic [4:0] scale;
    logic [5:0] shamt;
    logic [dzcd_pkg::ACC_W-1:0] shifted;
    logic [dzcd_pkg::ACC_W-1:0] ext_in;

    assign mask = (l < 2) ? mask_a : mask_b;
    assign scale = (l < 2) ? scale_a : scale_b;
    assign ext_in = {{(dzcd_pkg::ACC_W-dzcd_pkg::SMP_W){lane_in[l][15]}},
                     lane_in[l]};

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        for (int s = 0; s < dzcd_pkg::NSTAGE; s++) begin
          integ_q[s] <= '0;
        end
      end else begin
        integ_q[0] <= integ_q[0] + ext_in;
        for (int s = 1; s < dzcd_pkg::NSTAGE; s++) begin
          integ_q[s] <= integ_q[s] + integ_q[s-1];
        end
      end
    end

    // shift down by 36 minus scale
    assign shamt = 6'(dzcd_pkg::SHIFT_BASE) - {1'b0, scale};
    assign shifted = $signed(integ_q[dzcd_pkg::NSTAGE-1]) >>> shamt;
    assign cx[0] = shifted[dzcd_pkg::COMB_W-1:0];

    // delay one or two per stage
    for (genvar s = 0; s < dzcd_pkg::NSTAGE; s++) begin : g_comb
      assign cx[s+1] = cx[s] - (mask[s] ? d2_q[s] : d1_q[s]);
    end

    // comb stages run at decimated rate
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        for (int s = 0; s < dzcd_pkg::NSTAGE; s++) begin
          d1_q[s] <= '0;
          d2_q[s] <= '0;
        end
        res_q <= '0;
      end else if (dec_tick) begin
        for (int s = 0; s < dzcd_pkg::NSTAGE; s++) begin
          d1_q[s] <= cx[s];
          d2_q[s] <= d1_q[s];
        end
        res_q <= cic_gain ? (cx[dzcd_pkg::NSTAGE] << dzcd_pkg::GAIN12_SH)
                          : cx[dzcd_pkg::NSTAGE];
      end
    end
    assign lane_out[l] = res_q;
  end

  // ------------------------------------------------------------
  // Output stage
  // ------------------------------------------------------------
  logic [dzcd_pkg::COMB_W-1:0] byp [4];
  for (genvar l = 0; l < 4; l++) begin : g_byp
    assign byp[l] = {{(dzcd_pkg::COMB_W-dzcd_pkg::SMP_W){lane_in[l][15]}},
                     lane_in[l]};
  end

  // strobe per ratio, or every cycle in bypass
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= cic_bypass | dec_tick;
    end
  end

  logic [dzcd_pkg::COMB_W-1:0] sel [4];
  for (genvar l = 0; l < 4; l++) begin : g_sel
    assign sel[l] = cic_bypass ? byp[l] : lane_out[l];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_a <= '0;
      out_b <= '0;
    end else if (cic_bypass || dec_tick) begin
      out_a <= {sel[0], sel[1]};
      out_b <= two_chan ? {sel[2], sel[3]} : '0;
    end
  end
endmodule : dzcd_front
`default_nettype wire

// ---- hdl/dzcd_pkg.sv ----
// Constants and types of the delay, zero-pad and decimator front end
// Operation
// - Eight-entry delay memory, counter-driven write pointer, read from offset.
// - Bigger coarse offset gives longer delay, one input sample per step.
// - Zero stuffing lifts input rate to the processing clock rate.
// - Zero positions follow the fine sync plus the fine offset.
// - Coarse and fine offsets are staged, loaded on register sync.
// - Each channel has a 3-bit coarse offset; B used in two-channel mode.
// - Each channel has a 3-bit fine offset; B used in two-channel mode.
// - Shared 3-bit interpolation code picks factor 1, 2, 4 or 8.
// - Shared 3-bit selector picks the fine zero-stuff sync.
// - Shared 3-bit selector picks the staged-register load sync.
// - Six-stage decimator, ratios 1 to 32.
// - Separate I and Q decimators; second pair for channel B.
// - Six 54-bit integrators then six 24-bit comb stages.
// - Each comb stage delay one or two from a per-channel 6-bit mask.
// - Shift last integrator down by 36 minus the channel scale.
// - No saturation anywhere; overflow wraps.
// - Decimation ratio is 5-bit field plus one, shared by A and B.
// - 5-bit channel scale, each step doubles shifter output.
// - Extra gain bit adds fixed 12 dB at decimator output.
// - Bypass bit routes samples around the decimator.
// - 3-bit selector picks the sync aligning decimator output.
// - Gain is ratio^6 times 2 per delay-two stage times 2^(scale-36).
// - 2-bit rate field picks input rate of clock, /2, /4 or /8.
package dzcd_pkg;
  localparam int unsigned DLY_DEPTH = 8;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned NSTAGE = 6;
  localparam int unsigned ACC_W = 54;
  localparam int unsigned COMB_W = 24;
  localparam int unsigned SHIFT_BASE = 36;
  localparam int unsigned GAIN12_SH = 2;
  localparam int unsigned SMP_W = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_SYNC = 8'h08;
  localparam logic [7:0] OFS_CIC = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  // Control fields
  localparam int unsigned CT_TWO = 0;
  localparam int unsigned CT_RATE = 1;
  localparam int unsigned CT_INTERP = 4;
  localparam int unsigned CT_GAIN = 7;
  localparam int unsigned CT_BYP = 8;
  localparam int unsigned CT_DEC = 16;
  // Delay fields
  localparam int unsigned DL_CA = 0;
  localparam int unsigned DL_CB = 4;
  localparam int unsigned DL_FA = 8;
  localparam int unsigned DL_FB = 12;
  // Sync selector fields
  localparam int unsigned SY_FINE = 0;
  localparam int unsigned SY_REG = 4;
  localparam int unsigned SY_CIC = 8;
  // Decimator fields
  localparam int unsigned CI_SA = 0;
  localparam int unsigned CI_SB = 8;
  localparam int unsigned CI_MA = 16;
  localparam int unsigned CI_MB = 24;
  // Status fields
  localparam int unsigned ST_DEC = 16;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0003_0000;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  typedef struct packed {
    logic [SMP_W-1:0] i;
    logic [SMP_W-1:0] q;
  } dzcd_iq_s;
  typedef struct packed {
    logic [COMB_W-1:0] i;
    logic [COMB_W-1:0] q;
  } dzcd_out_s;
endpackage : dzcd_pkg

// ---- sim/dzcd_feed.sv ----
// Upstream sample source holding constant I and Q levels
`timescale 1ns/1ns
`default_nettype none
module dzcd_feed (
  input wire logic ref_clk,
  input wire logic [15:0] lvl_a,
  input wire logic [15:0] lvl_b,
  output var dzcd_pkg::dzcd_iq_s smp_a,
  output var dzcd_pkg::dzcd_iq_s smp_b
);
  // Held samples, Q carries the negated level
  always_ff @(posedge ref_clk) begin
    smp_a <= '{i: lvl_a, q: 16'h0000 - lvl_a};
    smp_b <= '{i: lvl_b, q: 16'h0000 - lvl_b};
  end
endmodule : dzcd_feed
`default_nettype wire

// ---- sim/dzcd_front_bench.sv ----
// Self-checking bench for the delay, zero-pad and decimator front end
`timescale 1ns/1ns
`default_nettype none
module dzcd_front_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] sync_in = 8'h00;
  logic [15:0] lvl_a = 16'h4000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic out_valid;
  dzcd_pkg::dzcd_iq_s in_a;
  dzcd_pkg::dzcd_iq_s in_b;
  dzcd_pkg::dzcd_out_s out_a;
  dzcd_pkg::dzcd_out_s out_b;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #20 ref_clk = ~ref_clk;
  dzcd_feed u_dzcd_feed (.ref_clk(ref_clk), .lvl_a(lvl_a),
    .lvl_b(16'hc000), .smp_a(in_a), .smp_b(in_b));
  dzcd_front u_dzcd_front (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_in(sync_in), .in_a(in_a), .in_b(in_b), .out_valid(out_valid),
    .out_a(out_a), .out_b(out_b));
  // ----
  // Tasks
  // ----
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] x, input logic xe);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1);
    if (!w) check("read data", prdata & m, x);
    check("error flag", {31'h0, pslverr}, {31'h0, xe});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic sync_pulse(input int b);
    sync_in <= 8'h01 << b;
    @(posedge ref_clk);
    sync_in <= 8'h00;
    @(posedge ref_clk);
  endtask : sync_pulse
  task automatic wait_valid(input int k, output int n);
    repeat (k) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (out_valid !== 1'b1);
    end
  endtask : wait_valid
  // Cycles from a level step until it shows at the bypass output
  task automatic step_time(input logic [15:0] v, output int n);
    lvl_a <= v;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (out_a.i !== {8'h00, v});
  endtask : step_time
  // Cycles from a fine sync until the first padded sample shows
  task automatic fine_time(output int n);
    sync_in <= 8'h01;
    @(posedge ref_clk);
    sync_in <= 8'h00;
    n = 0;
    @(posedge ref_clk);
    do begin
      @(posedge ref_clk);
      n++;
    end while (out_a.i === 24'h0 || n < 2);
  endtask : fine_time
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin : main
    logic [31:0] ctl_t [5] = '{32'h0003_0001, 32'h0003_0001,
      32'h0003_0001, 32'h0003_0001, 32'h0003_0081};
    logic [31:0] cic_t [5] = '{32'h0000_1818, 32'h0000_1919,
      32'h0101_1717, 32'h2121_1616, 32'h0000_1818};
    logic [31:0] exp_t [5] = '{32'h4000, 32'h8000, 32'h4000, 32'h4000,
      32'h10000};
    int n;
    int m;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (20) @(posedge ref_clk);
    // Second reset clears what the unreset delay memory fed in
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    apb(0, 8'h00, 0, '1, dzcd_pkg::CTRL_RST, 0);
    apb(0, 8'h04, 0, '1, 32'h0, 0);
    apb(0, 8'h10, 0, 32'h7777, 32'h0, 0);
    apb(0, 8'h14, 0, '1, 32'h0, 1);
    apb(1, 8'h10, 32'hffff, 0, 0, 1);
    $display("register test done");
    apb(1, 8'h08, 32'h0000_0520, 0, 0, 0);
    apb(1, 8'h04, 32'h0000_5371, 0, 0, 0);
    apb(0, 8'h10, 0, 32'h7777, 32'h0, 0);
    sync_pulse(3);
    apb(0, 8'h10, 0, 32'h7777, 32'h0, 0);
    sync_pulse(2);
    apb(0, 8'h10, 0, 32'h7777, 32'h5371, 0);
    $display("staged delay test done");
    wait_valid(1, n);
    sync_pulse(5);
    wait_valid(1, n);
    check("sync to output", n, 4);
    $display("decimation sync test done");
    for (int k = 0; k < 5; k++) begin
      apb(1, 8'h00, ctl_t[k], 0, 0, 0);
      apb(1, 8'h0c, cic_t[k], 0, 0, 0);
      wait_valid(30, n);
      check("a in-phase", {8'h0, out_a.i}, exp_t[k]);
      check("a quadrature", {8'h0, out_a.q},
            {8'h0, 24'h0 - exp_t[k][23:0]});
      check("b in-phase", {8'h0, out_b.i},
            {8'h0, 24'h0 - exp_t[k][23:0]});
      check("b quadrature", {8'h0, out_b.q}, exp_t[k]);
    end
    $display("gain test done");
    apb(1, 8'h0c, 32'h0000_1616, 0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'h00, 32'h0007_0000 | (k << 4) | (k << 1), 0, 0, 0);
      wait_valid(30, n);
      check("padded level", {8'h0, out_a.i}, 32'h40000 >> k);
    end
    $display("zero-pad test done");
    apb(1, 8'h00, 32'h001f_0000, 0, 0, 0);
    wait_valid(2, n);
    wait_valid(1, n);
    check("ratio period", n, 32);
    apb(1, 8'h00, 32'h0003_0100, 0, 0, 0);
    repeat (3) @(posedge ref_clk);
    repeat (8) begin
      @(posedge ref_clk);
      check("bypass strobe", {31'h0, out_valid}, 32'h1);
    end
    check("bypass sample", {8'h0, out_a.i}, 32'h4000);
    $display("bypass test done");
    apb(1, 8'h04, 32'h0, 0, 0, 0);
    sync_pulse(2);
    step_time(16'h1000, n);
    apb(1, 8'h04, 32'h0000_0003, 0, 0, 0);
    sync_pulse(2);
    step_time(16'h2000, m);
    check("coarse delay", m - n, 3);
    $display("coarse delay test done");
    apb(1, 8'h00, 32'h0003_0136, 0, 0, 0);
    apb(1, 8'h04, 32'h0, 0, 0, 0);
    sync_pulse(2);
    fine_time(n);
    apb(1, 8'h04, 32'h0000_0300, 0, 0, 0);
    sync_pulse(2);
    fine_time(m);
    check("fine offset", m - n, 3);
    $display("fine offset test done");
    report_and_stop();
  end
endmodule : dzcd_front_bench
`default_nettype wire

// ---- sim/dzcd_front_properties.sv ----
// Port checker for the delay, zero-pad and decimator front end
`timescale 1ns/1ns
`default_nettype none
module dzcd_front_chk #(
  parameter int unsigned NUM_SYNC = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_SYNC-1:0] sync_in,
  input wire logic out_valid,
  input wire dzcd_pkg::dzcd_out_s out_a,
  input wire dzcd_pkg::dzcd_out_s out_b
);
  // ----
  // Shadow of control state
  // ----
  logic [31:0] ctrl_q;
  logic [2:0] dsel_q;
  logic [5:0] gap_q;
  logic clean_q;
  logic acc_wr;
  logic two;
  logic byp;
  logic dsync;
  assign acc_wr = psel && penable && pwrite && pready;
  assign two = ctrl_q[dzcd_pkg::CT_TWO];
  assign byp = ctrl_q[dzcd_pkg::CT_BYP];
  assign dsync = sync_in[dsel_q];
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= dzcd_pkg::CTRL_RST;
    end else if (acc_wr && paddr == dzcd_pkg::OFS_CTRL) begin
      ctrl_q <= pwdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dsel_q <= 3'h0;
    end else if (acc_wr && paddr == dzcd_pkg::OFS_SYNC) begin
      dsel_q <= pwdata[dzcd_pkg::SY_CIC +: 3];
    end
  end
  // Output spacing counter, void after any disturbance
  always_ff @(posedge ref_clk) begin
    if (reset || out_valid) begin
      gap_q <= 6'h01;
    end else if (gap_q != 6'h3f) begin
      gap_q <= gap_q + 6'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset || dsync || (acc_wr && paddr == dzcd_pkg::OFS_CTRL)) begin
      clean_q <= 1'b0;
    end else if (out_valid) begin
      clean_q <= 1'b1;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_err_phase: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  chk_err_unmapped: assert property (psel && penable &&
    !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) |-> pslverr)
    else $error("unmapped access not refused");
  chk_stat_readonly: assert property (psel && penable && pwrite &&
    paddr == dzcd_pkg::OFS_STAT |-> pslverr)
    else $error("status write not refused");
  chk_dec_period: assert property (
    out_valid && clean_q && !byp |->
    gap_q == {1'b0, ctrl_q[dzcd_pkg::CT_DEC +: 5]} + 6'h01)
    else $error("output spacing differs from ratio");
  chk_dec_sync: assert property (
    dsync && !byp |-> ##[1:40] out_valid)
    else $error("no output after decimation sync");
  chk_b_quiet: assert property (
    out_valid && !two && !$past(two) |-> out_b == '0)
    else $error("channel b active in one-channel mode");
  chk_hold_out: assert property (
    !out_valid && clean_q |-> $stable(out_a))
    else $error("output changed between strobes");
  chk_bypass_rate: assert property (
    byp && $past(byp) && $past(byp, 2) |-> out_valid)
    else $error("bypass output not every cycle");
endmodule : dzcd_front_chk
bind dzcd_front dzcd_front_chk #(.NUM_SYNC(NUM_SYNC)) u_dzcd_front_chk (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .sync_in(sync_in), .out_valid(out_valid),
  .out_a(out_a), .out_b(out_b));
`default_nettype wire
